// ==== hw/fsq_params.svh ====
// Register offsets, fields, reset values and timing counts of the sequencer
`ifndef FSQ_PARAMS_SVH
`define FSQ_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FSQ_OFF_ADDR_LOW 4'h0
`define FSQ_OFF_ADDR_HIGH 4'h1
`define FSQ_OFF_DATA_LOW 4'h2
`define FSQ_OFF_DATA_HIGH 4'h3
`define FSQ_OFF_CONTROL 4'h4
`define FSQ_OFF_UNLOCK 4'h5
`define FSQ_OFF_STATUS 4'h6

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define FSQ_BIT_START 1
`define FSQ_BIT_WRITE_ENABLE_BIT 2
`define FSQ_BIT_WRITE_ERROR_FLAG 3
`define FSQ_BIT_ERASE 4
`define FSQ_BIT_LOAD_LATCHES_ONLY 5
`define FSQ_BIT_CONFIG_SPACE_SELECT 6
`define FSQ_CTRL_RESET 8'h80

// ----------------------------------------------------------------------
// Unlock pattern, latch values and address high read value
// ----------------------------------------------------------------------
`define FSQ_UNLOCK_FIRST 8'h55
`define FSQ_UNLOCK_SECOND 8'hAA
`define FSQ_LATCH_BLANK 14'h3FFF
`define FSQ_ADDRH_UNUSED 8'h80

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FSQ_CLK_MHZ 250
`define FSQ_OP_TIME_US 2000
`define FSQ_OP_CYCLES (`FSQ_OP_TIME_US * `FSQ_CLK_MHZ)
`define FSQ_SETUP_CYCLES 2

`endif

// ==== hw/fsq_pkg.sv ====
// Types shared by the flash sequencer modules
package fsq_pkg;

    typedef enum logic [2:0] {
        FSQ_IDLE = 3'b000,
        FSQ_SETUP = 3'b001,
        FSQ_LOAD = 3'b010,
        FSQ_ERASE = 3'b011,
        FSQ_PROG = 3'b100,
        FSQ_BLANK = 3'b101
    } fsq_state_e;

    typedef enum logic [1:0] {
        FSQ_UNL_NONE = 2'b00,
        FSQ_UNL_FIRST = 2'b01,
        FSQ_UNL_ARMED = 2'b10
    } fsq_unlock_e;

endpackage

// ==== hw/fsq_unlock.sv ====
// Unlock pattern detector for the flash sequencer
`timescale 1ns/1ps
`include "fsq_params.svh"

module fsq_unlock
    import fsq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic unlock_wr,
    input wire logic [7:0] unlock_data,
    input wire logic other_access,
    input wire logic consume,
    output logic armed
);

    fsq_unlock_e state_reg;

    // ------------------------------------------------------------------
    // Pattern tracking
    // ------------------------------------------------------------------
    // Any access other than the pattern breaks it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_reg <= FSQ_UNL_NONE;
        else if (consume)
            state_reg <= FSQ_UNL_NONE;
        else if (unlock_wr)
        begin
            if (unlock_data == `FSQ_UNLOCK_FIRST)
                state_reg <= FSQ_UNL_FIRST;
            else if (unlock_data == `FSQ_UNLOCK_SECOND
                     && state_reg == FSQ_UNL_FIRST)
                state_reg <= FSQ_UNL_ARMED;
            else
                state_reg <= FSQ_UNL_NONE;
        end
        else if (other_access)
            state_reg <= FSQ_UNL_NONE;
    end

    assign armed = (state_reg == FSQ_UNL_ARMED);

endmodule

// ==== hw/fsq_latches.sv ====
// Row of write latches with blank reset
`timescale 1ns/1ps
`include "fsq_params.svh"

module fsq_latches
#(
    parameter int NUM_LATCHES = 32,
    parameter int IDX_W = 5,
    parameter int DATA_W = 14
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [IDX_W-1:0] index,
    input wire logic [DATA_W-1:0] data,
    input wire logic blank,
    input wire logic [IDX_W-1:0] rd_index,
    output logic [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] latch_reg [NUM_LATCHES];

    // ------------------------------------------------------------------
    // Latch storage
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_LATCHES; i++)
        begin : g_latch
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    latch_reg[i] <= `FSQ_LATCH_BLANK;
                else if (blank)
                    latch_reg[i] <= `FSQ_LATCH_BLANK;
                else if (load && index == IDX_W'(i))
                    latch_reg[i] <= data;
            end
        end
    endgenerate

    assign rd_data = latch_reg[rd_index];

endmodule

// ==== hw/fsq_sequencer.sv ====
// Flash row erase and write sequencer, top level
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "fsq_params.svh"

module fsq_sequencer
    import fsq_pkg::*;
#(
    parameter int OP_CYCLES = `FSQ_OP_CYCLES,
    parameter int NUM_LATCHES = 32,
    parameter int ROW_W = 10,
    parameter int IDX_W = 5,
    parameter int DATA_W = 14
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic core_stall,
    output logic core_skip,
    output logic flash_erase,
    output logic flash_prog,
    output logic [ROW_W-1:0] flash_row,
    output logic [IDX_W-1:0] flash_col,
    output logic [DATA_W-1:0] flash_wdata,
    output logic flash_wstrobe,
    input wire logic flash_busy
);

    localparam int CNT_W = $clog2(OP_CYCLES + 1);
    localparam int ADDR_W = ROW_W + IDX_W;

    fsq_state_e state_reg;
    logic [7:0] addr_low_reg;
    logic [6:0] addr_high_reg;
    logic [7:0] data_low_reg;
    logic [5:0] data_high_reg;
    logic config_space_select_reg;
    logic load_latches_only_reg;
    logic erase_reg;
    logic write_enable_bit_reg;
    logic start_reg;
    logic write_error_flag_reg;
    logic busy_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [IDX_W-1:0] col_reg;
    logic [ROW_W-1:0] row_reg;
    logic [7:0] reg_rdata_reg;
    logic armed;
    logic launch;
    logic done;
    logic blank;
    logic latch_load;
    logic [DATA_W-1:0] latch_rd;
    logic [ADDR_W-1:0] full_addr;
    logic busy_s1_reg;
    logic busy_s2_reg;
    logic ctrl_wr;
    logic start_req;
    logic setup_done;

    assign full_addr = {addr_high_reg, addr_low_reg};
    assign ctrl_wr = reg_wr && reg_addr == `FSQ_OFF_CONTROL;
    assign start_req = ctrl_wr && reg_wdata[`FSQ_BIT_START];

    // ------------------------------------------------------------------
    // Unlock detector and latch row
    // ------------------------------------------------------------------
    fsq_unlock u_unlock (
        .clk(clk),
        .rst(rst),
        .unlock_wr(reg_wr && reg_addr == `FSQ_OFF_UNLOCK),
        .unlock_data(reg_wdata),
        .other_access((reg_wr && reg_addr != `FSQ_OFF_UNLOCK
                       && !start_req) || reg_rd),
        .consume(start_req),
        .armed(armed)
    );

    fsq_latches #(
        .NUM_LATCHES(NUM_LATCHES),
        .IDX_W(IDX_W),
        .DATA_W(DATA_W)
    ) u_latches (
        .clk(clk),
        .rst(rst),
        .load(latch_load),
        .index(full_addr[IDX_W-1:0]),
        .data({data_high_reg, data_low_reg}),
        .blank(blank),
        .rd_index(col_reg),
        .rd_data(latch_rd)
    );

    // ------------------------------------------------------------------
    // Launch decision
    // ------------------------------------------------------------------
    // Needs write enable, pattern, program space and no operation running
    assign launch = start_req && armed && write_enable_bit_reg && !config_space_select_reg
                    && state_reg == FSQ_IDLE;
    assign setup_done = cnt_reg == CNT_W'(`FSQ_SETUP_CYCLES - 1);
    assign latch_load = state_reg == FSQ_SETUP && setup_done
                        && !erase_reg;
    assign done = cnt_reg == CNT_W'(0) && !busy_s2_reg;
    assign blank = state_reg == FSQ_BLANK;

    // ------------------------------------------------------------------
    // Flash busy synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
        end
        else
        begin
            busy_s1_reg <= flash_busy;
            busy_s2_reg <= busy_s1_reg;
        end
    end

    // ------------------------------------------------------------------
    // Operation state machine
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= FSQ_IDLE;
            cnt_reg <= '0;
            col_reg <= '0;
            row_reg <= '0;
        end
        else
        begin
            unique case (state_reg)
                FSQ_IDLE:
                begin
                    if (launch)
                    begin
                        state_reg <= FSQ_SETUP;
                        cnt_reg <= '0;
                        // Row from upper bits, latch index ignored
                        row_reg <= full_addr[ADDR_W-1:IDX_W];
                    end
                end
                FSQ_SETUP:
                begin
                    if (setup_done)
                    begin
                        col_reg <= '0;
                        cnt_reg <= CNT_W'(OP_CYCLES - 1);
                        if (erase_reg)
                            state_reg <= FSQ_ERASE;
                        else if (load_latches_only_reg)
                            state_reg <= FSQ_IDLE;
                        else
                            state_reg <= FSQ_LOAD;
                    end
                    else
                        cnt_reg <= cnt_reg + CNT_W'(1);
                end
                FSQ_LOAD:
                begin
                    // One latch per cycle, never past the last one
                    col_reg <= col_reg + IDX_W'(1);
                    if (col_reg == IDX_W'(NUM_LATCHES - 1))
                        state_reg <= FSQ_PROG;
                end
                FSQ_ERASE, FSQ_PROG:
                begin
                    if (cnt_reg != CNT_W'(0))
                        cnt_reg <= cnt_reg - CNT_W'(1);
                    if (done)
                        state_reg <= FSQ_BLANK;
                end
                FSQ_BLANK:
                    state_reg <= FSQ_IDLE;
                default:
                    state_reg <= FSQ_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Flash array strobes
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flash_erase <= 1'b0;
            flash_prog <= 1'b0;
            flash_wstrobe <= 1'b0;
            flash_row <= '0;
            flash_col <= '0;
            flash_wdata <= '0;
        end
        else
        begin
            flash_erase <= state_reg == FSQ_ERASE;
            flash_prog <= state_reg == FSQ_PROG;
            flash_wstrobe <= state_reg == FSQ_LOAD;
            flash_row <= row_reg;
            flash_col <= col_reg;
            flash_wdata <= latch_rd;
        end
    end

    // ------------------------------------------------------------------
    // Core stall and skip
    // ------------------------------------------------------------------
    // Core forced idle for the two setup slots, runs the third instruction in the
    // next cycle, then is stalled during the self-timed phase and resumes at the fourth
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            busy_reg <= 1'b0;
        else
            busy_reg <= state_reg == FSQ_LOAD || state_reg == FSQ_ERASE
                        || state_reg == FSQ_PROG;
    end

    assign core_skip = state_reg == FSQ_SETUP;
    assign core_stall = busy_reg || state_reg == FSQ_BLANK;

    // ------------------------------------------------------------------
    // Address and data registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            addr_low_reg <= '0;
            addr_high_reg <= '0;
            data_low_reg <= '0;
            data_high_reg <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `FSQ_OFF_ADDR_LOW)
                addr_low_reg <= reg_wdata;
            if (reg_addr == `FSQ_OFF_ADDR_HIGH)
                addr_high_reg <= reg_wdata[6:0];
            if (reg_addr == `FSQ_OFF_DATA_LOW)
                data_low_reg <= reg_wdata;
            if (reg_addr == `FSQ_OFF_DATA_HIGH)
                data_high_reg <= reg_wdata[5:0];
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            config_space_select_reg <= 1'b0;
            load_latches_only_reg <= 1'b0;
            write_enable_bit_reg <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            config_space_select_reg <= reg_wdata[`FSQ_BIT_CONFIG_SPACE_SELECT];
            load_latches_only_reg <= reg_wdata[`FSQ_BIT_LOAD_LATCHES_ONLY];
            write_enable_bit_reg <= reg_wdata[`FSQ_BIT_WRITE_ENABLE_BIT];
        end
    end

    // Erase select cleared when its erase completes; clear wins over write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            erase_reg <= 1'b0;
        else if (state_reg == FSQ_ERASE && done)
            erase_reg <= 1'b0;
        else if (ctrl_wr && state_reg == FSQ_IDLE)
            erase_reg <= reg_wdata[`FSQ_BIT_ERASE];
    end

    // Start bit: software can only set it, hardware clears at the end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            start_reg <= 1'b0;
        else if (launch)
            start_reg <= 1'b1;
        else if (state_reg == FSQ_BLANK || (latch_load && load_latches_only_reg))
            start_reg <= 1'b0;
    end

    // Error flag survives reset; set wins over a software clear
    logic op_active_reg;
    always_ff @(posedge clk)
        op_active_reg <= state_reg != FSQ_IDLE && !rst;

    always_ff @(posedge clk)
    begin
        if (rst)
            write_error_flag_reg <= write_error_flag_reg || op_active_reg;
        else if (start_req && !launch)
            write_error_flag_reg <= 1'b1;
        else if (ctrl_wr)
            write_error_flag_reg <= reg_wdata[`FSQ_BIT_WRITE_ERROR_FLAG];
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata_reg <= '0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `FSQ_OFF_ADDR_LOW: reg_rdata_reg <= addr_low_reg;
                `FSQ_OFF_ADDR_HIGH:
                    reg_rdata_reg <= `FSQ_ADDRH_UNUSED | {1'b0, addr_high_reg};
                `FSQ_OFF_DATA_LOW: reg_rdata_reg <= data_low_reg;
                `FSQ_OFF_DATA_HIGH: reg_rdata_reg <= {2'h0, data_high_reg};
                `FSQ_OFF_CONTROL:
                    reg_rdata_reg <= {1'b1, config_space_select_reg, load_latches_only_reg, erase_reg,
                                      write_error_flag_reg, write_enable_bit_reg,
                                      start_reg, 1'b0};
                `FSQ_OFF_STATUS:
                    reg_rdata_reg <= {5'h00, state_reg};
                default: reg_rdata_reg <= 8'h00;
            endcase
        end
        else
            reg_rdata_reg <= 8'h00;
    end

    assign reg_rdata = reg_rdata_reg;

endmodule

// ==== verif/fsq_sequencer_sva.sv ====
// Port-level assertions for the flash sequencer
`timescale 1ns/1ps

module fsq_sequencer_sva
#(
    parameter int OP_CYCLES = 20,
    parameter int ROW_W = 10,
    parameter int IDX_W = 5
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic core_stall,
    input wire logic core_skip,
    input wire logic flash_erase,
    input wire logic flash_prog,
    input wire logic [ROW_W-1:0] flash_row,
    input wire logic [IDX_W-1:0] flash_col,
    input wire logic flash_wstrobe
);
    logic [19:0] erase_len;

    // ------
    // Length of the current erase pulse
    // ------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            erase_len <= '0;
        else if (flash_erase)
            erase_len <= erase_len + 20'h00001;
        else
            erase_len <= '0;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence skip_pair;
        core_skip [*2] ##1 !core_skip;
    endsequence

    sequence last_word;
        flash_wstrobe && flash_col == '1;
    endsequence

    skip_len_a: assert property ($rose(core_skip) |-> skip_pair)
        else $error("forced no-op window is not two cycles");
    erase_stall_a: assert property (flash_erase |-> core_stall)
        else $error("core runs during erase");
    prog_stall_a: assert property (flash_prog |-> core_stall)
        else $error("core runs during row programming");
    no_auto_erase_a: assert property (flash_prog |-> !flash_erase)
        else $error("erase raised during programming");
    col_step_a: assert property (flash_wstrobe && flash_col != '1 |=>
        flash_wstrobe && flash_col == $past(flash_col) + 1'b1)
        else $error("latch transfer column did not step by one");
    word_count_a: assert property (last_word |=>
        !flash_wstrobe ##[0:8] flash_prog)
        else $error("transfer exceeded 32 words or no programming");
    row_hold_a: assert property (flash_wstrobe ##1 flash_wstrobe |->
        $stable(flash_row))
        else $error("row changed inside one latch transfer");
    erase_row_a: assert property (flash_erase ##1 flash_erase |->
        $stable(flash_row))
        else $error("row changed during erase");
    erase_len_a: assert property ($fell(flash_erase) |->
        erase_len >= OP_CYCLES - 1)
        else $error("erase pulse shorter than the timed interval");
endmodule

bind fsq_sequencer fsq_sequencer_sva #(
    .OP_CYCLES(OP_CYCLES),
    .ROW_W(ROW_W),
    .IDX_W(IDX_W)
) u_sva (
    .clk(clk),
    .rst(rst),
    .core_stall(core_stall),
    .core_skip(core_skip),
    .flash_erase(flash_erase),
    .flash_prog(flash_prog),
    .flash_row(flash_row),
    .flash_col(flash_col),
    .flash_wstrobe(flash_wstrobe)
);

// ==== verif/fsq_flash_model.sv ====
// Behavioural flash array facing the sequencer's latch transfer bus
`timescale 1ns/1ps

module fsq_flash_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic flash_erase,
    input wire logic flash_prog,
    input wire logic [9:0] flash_row,
    input wire logic [4:0] flash_col,
    input wire logic [13:0] flash_wdata,
    input wire logic flash_wstrobe,
    output logic flash_busy
);
    logic [13:0] mem [32768];
    logic [13:0] lat [32];
    logic e_q;
    logic p_q;
    int bcnt;
    int erase_cnt = 0;
    int prog_cnt = 0;

    initial foreach (mem[i]) mem[i] = 14'h3FFF;

    // Slow mode holds busy well past the sequencer's own timer
    assign flash_busy = (bcnt != 0);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            e_q <= 1'b0;
            p_q <= 1'b0;
            bcnt <= 0;
        end
        else
        begin
            e_q <= flash_erase;
            p_q <= flash_prog;
            if (flash_wstrobe)
                lat[flash_col] <= flash_wdata;
            if ((flash_erase && !e_q) || (flash_prog && !p_q))
                bcnt <= slow ? 40 : 0;
            else if (bcnt != 0)
                bcnt <= bcnt - 1;
            if (flash_erase && !e_q)
            begin
                erase_cnt <= erase_cnt + 1;
                for (int i = 0; i < 32; i++)
                    mem[{flash_row, i[4:0]}] <= 14'h3FFF;
            end
            // Programming only clears bits, never erases
            if (flash_prog && !p_q)
            begin
                prog_cnt <= prog_cnt + 1;
                for (int i = 0; i < 32; i++)
                    mem[{flash_row, i[4:0]}] <=
                        mem[{flash_row, i[4:0]}] & lat[i];
            end
        end
    end
endmodule

// ==== verif/testbench.sv ====
// Register-level testbench of the flash sequencer
`timescale 1ns/1ps
`include "fsq_params.svh"

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s expected %h seen %h", n, e, g); \
    end end

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow = 1'b0;
    logic [7:0] reg_rdata;
    logic core_stall;
    logic core_skip;
    logic flash_erase;
    logic flash_prog;
    logic flash_wstrobe;
    logic flash_busy;
    logic [9:0] flash_row;
    logic [4:0] flash_col;
    logic [13:0] flash_wdata;
    logic [7:0] rv;
    bit sk;
    bit st;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;

    always #2 clk = ~clk;

    fsq_sequencer #(.OP_CYCLES(20)) uut (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_stall(core_stall),
        .core_skip(core_skip), .flash_erase(flash_erase),
        .flash_prog(flash_prog), .flash_row(flash_row),
        .flash_col(flash_col), .flash_wdata(flash_wdata),
        .flash_wstrobe(flash_wstrobe), .flash_busy(flash_busy));

    fsq_flash_model flash (.clk(clk), .rst(rst), .slow(slow),
        .flash_erase(flash_erase), .flash_prog(flash_prog),
        .flash_row(flash_row), .flash_col(flash_col),
        .flash_wdata(flash_wdata), .flash_wstrobe(flash_wstrobe),
        .flash_busy(flash_busy));

    // ------
    // Bus tasks
    // ------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic settle();
        sk = 0;
        st = 0;
        for (int i = 0; i < 400; i++)
        begin
            @(posedge clk);
            #1;
            if (core_skip === 1'b1)
                sk = 1;
            if (core_stall === 1'b1)
                st = 1;
            if (i > 10 && core_stall === 1'b0 && core_skip === 1'b0)
                break;
            if (i == 399)
                `CHK("op end", 1'b0, core_stall)
        end
    endtask

    task automatic go(input logic [7:0] ctl);
        wr(`FSQ_OFF_UNLOCK, `FSQ_UNLOCK_FIRST);
        wr(`FSQ_OFF_UNLOCK, `FSQ_UNLOCK_SECOND);
        wr(`FSQ_OFF_CONTROL, ctl | 8'h02);
        settle();
    endtask

    task automatic word(input logic [9:0] r, input logic [4:0] c,
        input logic [13:0] d, input logic [7:0] ctl);
        wr(`FSQ_OFF_ADDR_LOW, {r[2:0], c});
        wr(`FSQ_OFF_ADDR_HIGH, {1'b0, r[9:3]});
        wr(`FSQ_OFF_DATA_LOW, d[7:0]);
        wr(`FSQ_OFF_DATA_HIGH, {2'b00, d[13:8]});
        wr(`FSQ_OFF_CONTROL, ctl);
        go(ctl);
    endtask

    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    // ------
    // Tests
    // ------
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`FSQ_OFF_CONTROL, rv);
        `CHK("control reset", `FSQ_CTRL_RESET, rv & 8'hF7)
        rd(`FSQ_OFF_UNLOCK, rv);
        `CHK("unlock read", 8'h00, rv)
        rd(4'hF, rv);
        `CHK("unmapped read", 8'h00, rv)
        $display("test reset done");
        word(10'h005, 5'h02, 14'h1234, 8'h24);
        `CHK("load skip", 1'b1, sk)
        `CHK("load stall", 1'b0, st)
        `CHK("load only", 0, flash.prog_cnt)
        word(10'h005, 5'h09, 14'h0ABC, 8'h24);
        word(10'h005, 5'h1F, 14'h2001, 8'h04);
        `CHK("row stall", 1'b1, st)
        `CHK("row prog", 1, flash.prog_cnt)
        `CHK("word 2", 14'h1234, flash.mem[15'h00A2])
        `CHK("word 9", 14'h0ABC, flash.mem[15'h00A9])
        `CHK("word 31", 14'h2001, flash.mem[15'h00BF])
        `CHK("unloaded", 14'h3FFF, flash.mem[15'h00A0])
        `CHK("next row", 14'h3FFF, flash.mem[15'h00C2])
        $display("test row write done");
        word(10'h005, 5'h02, 14'h0F0F, 8'h04);
        `CHK("no erase", 14'h0204, flash.mem[15'h00A2])
        `CHK("latch blank", 14'h3FFF, flash.lat[9])
        $display("test rewrite done");
        slow <= 1'b1;
        word(10'h005, 5'h0D, 14'h0000, 8'h14);
        `CHK("erase stall", 1'b1, st)
        `CHK("erase count", 1, flash.erase_cnt)
        `CHK("erased 2", 14'h3FFF, flash.mem[15'h00A2])
        `CHK("erased 31", 14'h3FFF, flash.mem[15'h00BF])
        rd(`FSQ_OFF_CONTROL, rv);
        `CHK("start erase clr", 8'h00, rv & 8'h12)
        slow <= 1'b0;
        $display("test erase done");
        wr(`FSQ_OFF_CONTROL, 8'h24);
        wr(`FSQ_OFF_UNLOCK, `FSQ_UNLOCK_FIRST);
        wr(`FSQ_OFF_ADDR_LOW, 8'h00);
        wr(`FSQ_OFF_UNLOCK, `FSQ_UNLOCK_SECOND);
        wr(`FSQ_OFF_CONTROL, 8'h26);
        settle();
        `CHK("broken unlock", 1'b0, sk)
        rd(`FSQ_OFF_CONTROL, rv);
        `CHK("refused flag", 1'b1, rv[3])
        wr(`FSQ_OFF_CONTROL, 8'h20);
        go(8'h20);
        `CHK("no enable", 1'b0, sk)
        `CHK("no enable prog", 2, flash.prog_cnt)
        wr(`FSQ_OFF_CONTROL, 8'h44);
        go(8'h44);
        `CHK("config space", 1'b0, sk)
        $display("test refusals done");
        wr(`FSQ_OFF_CONTROL, 8'h14);
        wr(`FSQ_OFF_UNLOCK, `FSQ_UNLOCK_FIRST);
        wr(`FSQ_OFF_UNLOCK, `FSQ_UNLOCK_SECOND);
        wr(`FSQ_OFF_CONTROL, 8'h16);
        repeat (12) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("reset stall", 1'b0, core_stall)
        rd(`FSQ_OFF_CONTROL, rv);
        `CHK("abort flag", 1'b1, rv[3])
        wr(`FSQ_OFF_ADDR_HIGH, 8'h2B);
        rd(`FSQ_OFF_ADDR_HIGH, rv);
        `CHK("addr high", 8'hAB, rv)
        rd(`FSQ_OFF_STATUS, rv);
        `CHK("status idle", 8'h00, rv)
        $display("test abort done");
        wrap_up();
    end
endmodule
